// file: rtl/bsts_pkg.sv
package bsts_pkg;
	// controller clock and timing
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
	localparam int unsigned SYNC_DELAY_US = 2000;
	localparam int unsigned PG_DELAY_US   = 2000;
	localparam int unsigned BOOT_NS       = 300;
	localparam int unsigned TOG_WIN_US    = 5;
	localparam int unsigned SYNC_DELAY_CYC = SYNC_DELAY_US * CLK_PER_US;
	localparam int unsigned PG_DELAY_CYC   = PG_DELAY_US * CLK_PER_US;
	localparam int unsigned BOOT_CYC       = (BOOT_NS * CLK_PER_US + 999) / 1000;
	localparam int unsigned TOG_WIN_CYC    = TOG_WIN_US * CLK_PER_US;
	// amplifier offset taper, in mV
	localparam logic [7:0] OFFS_MV      = 8'h28;
	localparam logic [7:0] OFFS_SPAN_MV = 8'h46;
	// register map, byte addresses
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_CONFIG = 12'h008;
	localparam int unsigned CTRL_EN_BIT     = 0;
	localparam int unsigned CTRL_MASTER_BIT = 1;
	localparam logic [1:0]  CTRL_RST        = 2'h1;

	typedef enum logic [3:0] {
		ST_OFF     = 4'h0,
		ST_VCC_UP  = 4'h1,
		ST_VDD_UP  = 4'h3,
		ST_CONFIG  = 4'h2,
		ST_SYNC    = 4'h6,
		ST_ARMED   = 4'h7,
		ST_LG_HOLD = 4'h5,
		ST_BOOT    = 4'h4,
		ST_RUN     = 4'hc
	} bsts_state_t;

	// qualified comparator results and codes from the analog side
	typedef struct packed {
		logic       en_ok;
		logic       vcc_ok;
		logic       vdd_ok;
		logic       stop_bus_hi;
		logic       track_below_vref;
		logic       comp_above_low;
		logic       comp_above_ramp;
		logic       fb_above_uv;
		logic       fault_present;
		logic       fault_restart;
		logic       clk_lock;
		logic [1:0] i_above_avg;
		logic [1:0] i_below_avg;
		logic [2:0] phase_count_select;
		logic [7:0] track_mv;
	} bsts_pins_t;

	// sync-to-relay delay in degrees, 360/N
	function automatic logic [8:0] relay_deg(input logic [2:0] code);
		unique case (code)
			3'h0: relay_deg = 9'h05a;
			3'h1: relay_deg = 9'h078;
			3'h2: relay_deg = 9'h048;
			3'h3: relay_deg = 9'h03c;
			3'h4: relay_deg = 9'h02d;
			3'h5: relay_deg = 9'h024;
			default: relay_deg = 9'h01e;
		endcase
	endfunction : relay_deg

	function automatic logic [5:0] offset_mv(input logic [7:0] t);
		logic [15:0] p;
		p = 16'h0000;
		if (t >= OFFS_SPAN_MV) begin
			offset_mv = 6'h00;
		end else begin
			p = {8'h00, OFFS_MV} * {8'h00, OFFS_SPAN_MV - t};
			p = p / {8'h00, OFFS_SPAN_MV};
			offset_mv = p[5:0];
		end
	endfunction : offset_mv
endpackage : bsts_pkg

// file: rtl/bsts_sync.sv
`timescale 1ns/1ps
module bsts_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire  logic         clk,
	input  wire  logic         rst_n,
	// data
	input  wire  logic [W-1:0] d,
	output logic       [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bsts_sync_t;

	bsts_sync_t r_q, r_d;

	if (W < 1) begin : g_chk
		$error("bsts_sync: W must be at least 1");
	end

	always_comb begin
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign q = r_q.s2;
endmodule : bsts_sync

// file: rtl/bsts_timer.sv
`timescale 1ns/1ps
module bsts_timer #(
	parameter int unsigned CYC = 80000
) (
	// clock and reset
	input  wire  logic clk,
	input  wire  logic rst_n,
	// control
	input  wire  logic clear,
	input  wire  logic start,
	output logic       done
);
	localparam int unsigned W = $clog2(CYC + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
		logic         done;
	} bsts_tmr_t;

	bsts_tmr_t t_q, t_d;

	if (CYC < 1) begin : g_chk
		$error("bsts_timer: CYC must be at least 1");
	end

	// done holds until clear, so a level start cannot retrigger
	always_comb begin
		t_d = t_q;
		if (clear) begin
			t_d = '0;
		end else if (t_q.busy) begin
			if (t_q.cnt == '0) begin
				t_d.busy = 1'b0;
				t_d.done = 1'b1;
			end else begin
				t_d.cnt = t_q.cnt - W'(1);
			end
		end else if (start && !t_q.done) begin
			t_d.busy = 1'b1;
			t_d.cnt  = W'(CYC - 1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign done = t_q.done;
endmodule : bsts_timer

// file: rtl/bsts_seq.sv
// Operation
// R1: enable low keeps both regulators off and the controller in low power
// R2: enable starts logic regulator, then driver regulator, then ready-to-start
// R3: supplies already good at enable means ready-to-start at once
// R4: any supply lockout stops switching, standby, then full start-up again
// R5: at ready-to-start sample phase select, set phase count and relay delay
// R6: oscillator and PLL start only after phase configuration is set
// R7: after oscillator start wait 2 ms, then release the stop bus
// R8: stop bus rises when all release it; rising bus permits switching
// R9: low-bias amplifier stage while follow-reference below reference, else low-offset
// R10: below 70 mV follow-reference apply 40 mV offset tapering to zero
// R11: target is lesser of reference and follow-reference, driven up and down
// R12: fully synchronous switching always, except restart after a fault
// R13: ready to switch with loop voltage low holds low-side gate high
// R14: loop voltage rising gives 300 ns low-side pulse, then high-side switching
// R15: 2 ms power-good timer starts at first high-side pulse
// R16: on expiry output-ok only if sense, track, fault and lock conditions hold
// R17: phase above average current loses duty, below average gains duty
// R18: both gates low from enable low until stop bus rises
// R19: comparisons arrive synchronised, states advance only on the controller clock
`timescale 1ns/1ps
module bsts_seq
	import bsts_pkg::*;
#(
	parameter int unsigned SYNC_CYC = SYNC_DELAY_CYC,
	parameter int unsigned PG_CYC   = PG_DELAY_CYC
) (
	// clock and reset
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	// apb slave
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [11:0] paddr,
	input  wire  logic [31:0] pwdata,
	output logic              pready,
	output logic       [31:0] prdata,
	output logic              pslverr,
	// analog comparisons, asynchronous
	input  wire  bsts_pins_t  pins_async,
	// modulator request per phase, same clock
	input  wire  logic [1:0]  pwm_req,
	// supply sequencing
	output logic              vcc_reg_en,
	output logic              vdd_reg_en,
	output logic              low_power,
	output logic              ready_to_start,
	// phase configuration and clocking
	output logic       [2:0]  phase_cfg,
	output logic       [8:0]  relay_delay_deg,
	output logic              osc_en,
	// shared stop bus, open drain
	output logic              stop_bus_oe,
	// gate drive
	output logic       [1:0]  high_side_gate,
	output logic       [1:0]  low_side_gate,
	output logic              diode_emulation,
	// error amplifier control
	output logic              ea_low_bias_sel,
	output logic              ref_sel_track,
	output logic       [5:0]  ea_offset_mv,
	// current sharing trims
	output logic       [1:0]  duty_dec,
	output logic       [1:0]  duty_inc,
	// power good, open drain
	output logic              output_ok_flag,
	output logic              output_ok_oe
);
	localparam int unsigned TOG_W = $clog2(TOG_WIN_CYC + 1);

	if (BOOT_CYC < 1 || BOOT_CYC > 15) begin : g_chk
		$error("bsts_seq: boot pulse count out of range");
	end

	typedef struct packed {
		bsts_state_t      st;
		logic [1:0]       ctrl;
		logic [2:0]       ph_cfg;
		logic [8:0]       relay;
		logic [3:0]       boot_cnt;
		logic             pg_started;
		logic [TOG_W-1:0] tog_cnt;
		logic             lock_prev;
		logic             toggling;
		logic             vcc_en;
		logic             vdd_en;
		logic             low_pwr;
		logic             rts;
		logic             osc;
		logic             bus_pull;
		logic [1:0]       hg;
		logic [1:0]       lg;
		logic             diode;
		logic             low_bias;
		logic             ref_trk;
		logic [5:0]       offs;
		logic [1:0]       dec;
		logic [1:0]       inc;
		logic             ok;
		logic             ok_oe;
		logic             pready;
		logic [31:0]      prdata;
		logic             pslverr;
	} bsts_core_t;

	bsts_core_t q, d;
	bsts_pins_t s;
	logic       sync_done;
	logic       pg_done;

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_CONFIG);
	endfunction : addr_hit

	function automatic logic past_vdd(input bsts_state_t st);
		past_vdd = !(st inside {ST_OFF, ST_VCC_UP, ST_VDD_UP});
	endfunction : past_vdd

	// every comparison crosses two flops before use
	bsts_sync #(
		.W ($bits(bsts_pins_t))
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (pins_async),
		.q     (s)
	); // R19

	bsts_timer #(
		.CYC (SYNC_CYC)
	) u_sync_tmr (
		.clk   (pclk),
		.rst_n (presetn),
		.clear (q.st != ST_SYNC),
		.start (q.st == ST_SYNC),
		.done  (sync_done)
	); // R7

	bsts_timer #(
		.CYC (PG_CYC)
	) u_pg_tmr (
		.clk   (pclk),
		.rst_n (presetn),
		.clear (!q.pg_started),
		.start (q.pg_started),
		.done  (pg_done)
	); // R15

	always_comb begin
		logic en;
		logic sup;
		logic sw;
		logic master;
		logic cond;
		logic acc;
		en     = 1'b0;
		sup    = 1'b0;
		sw     = 1'b0;
		master = 1'b0;
		cond   = 1'b0;
		acc    = 1'b0;
		d      = q;

		en     = s.en_ok && q.ctrl[CTRL_EN_BIT];
		sup    = s.vcc_ok && s.vdd_ok;
		master = q.ctrl[CTRL_MASTER_BIT];

		// sequence
		if (!en) begin
			d.st = ST_OFF; // R1
		end else begin
			unique case (q.st)
				ST_OFF: begin
					d.st = sup ? ST_CONFIG : ST_VCC_UP; // R2 R3
				end
				ST_VCC_UP: begin
					if (s.vcc_ok) begin
						d.st = s.vdd_ok ? ST_CONFIG : ST_VDD_UP; // R2 R3
					end
				end
				ST_VDD_UP: begin
					if (!s.vcc_ok) begin
						d.st = ST_VCC_UP;
					end else if (s.vdd_ok) begin
						d.st = ST_CONFIG; // R2
					end
				end
				ST_CONFIG: begin
					d.st = ST_SYNC; // R6
				end
				ST_SYNC: begin
					if (sync_done) begin
						d.st = ST_ARMED; // R7
					end
				end
				ST_ARMED: begin
					if (s.stop_bus_hi) begin
						d.st = ST_LG_HOLD; // R8
					end
				end
				ST_LG_HOLD: begin
					if (s.comp_above_low) begin
						d.st       = ST_BOOT; // R14
						d.boot_cnt = 4'(BOOT_CYC - 1);
					end
				end
				ST_BOOT: begin
					if (q.boot_cnt == 4'h0) begin
						d.st = ST_RUN; // R14
					end else begin
						d.boot_cnt = q.boot_cnt - 4'h1;
					end
				end
				ST_RUN: begin
					d.st = ST_RUN;
				end
				default: begin
					d.st = ST_OFF;
				end
			endcase
			// a lockout drops to standby and restarts from the top
			if (!sup && past_vdd(q.st)) begin
				d.st = ST_VCC_UP; // R4
			end else if (!s.stop_bus_hi &&
			             (q.st inside {ST_LG_HOLD, ST_BOOT, ST_RUN})) begin
				// bus pulled low elsewhere: stop and wait for release
				d.st = ST_ARMED; // R8
			end
		end

		// latched on entering config, a cycle ahead of the oscillator
		if (d.st == ST_CONFIG) begin
			d.ph_cfg = s.phase_count_select; // R5
			d.relay  = relay_deg(s.phase_count_select); // R5
		end

		// outputs follow the next state so they leave flops in step
		d.low_pwr  = (d.st == ST_OFF); // R1
		d.vcc_en   = (d.st != ST_OFF); // R1 R2
		d.vdd_en   = !(d.st inside {ST_OFF, ST_VCC_UP}); // R2
		d.rts      = past_vdd(d.st); // R2 R3
		d.osc      = past_vdd(d.st) && (d.st != ST_CONFIG); // R6
		d.bus_pull = (d.st inside {ST_OFF, ST_VCC_UP, ST_VDD_UP,
		                           ST_CONFIG, ST_SYNC}); // R7

		// gates: floating node until the bus rises
		sw      = (d.st == ST_RUN);
		d.diode = s.fault_restart; // R12
		d.hg    = 2'h0; // R18
		d.lg    = 2'h0; // R18
		if (d.st inside {ST_LG_HOLD, ST_BOOT}) begin
			d.lg = 2'h3; // R13 R14
		end else if (sw) begin
			d.hg = pwm_req; // R14
			d.lg = s.fault_restart ? 2'h0 : ~pwm_req; // R12
		end

		// power-good delay from the first high-side pulse
		if (!sw) begin
			d.pg_started = 1'b0;
		end else if ((pwm_req != 2'h0) && s.comp_above_ramp) begin
			d.pg_started = 1'b1; // R15
		end

		// slave lock detect: an edge within the window counts as toggling
		d.lock_prev = s.clk_lock;
		if (s.clk_lock != q.lock_prev) begin
			d.tog_cnt  = TOG_W'(TOG_WIN_CYC);
			d.toggling = 1'b1;
		end else if (q.tog_cnt == '0) begin
			d.toggling = 1'b0;
		end else begin
			d.tog_cnt = q.tog_cnt - TOG_W'(1);
		end

		cond = (!master || s.fb_above_uv) && !s.track_below_vref &&
		       !s.fault_present && (master || q.toggling);
		d.ok = q.pg_started && d.pg_started && pg_done && cond; // R16
		d.ok_oe = !d.ok; // R16

		// error amplifier stage, target and offset
		d.low_bias = s.track_below_vref; // R9
		d.ref_trk  = s.track_below_vref; // R11
		d.offs     = offset_mv(s.track_mv); // R10

		// current sharing only while switching
		d.dec = sw ? s.i_above_avg : 2'h0; // R17
		d.inc = sw ? (s.i_below_avg & ~s.i_above_avg) : 2'h0; // R17

		// apb: no wait state, data prepared in the setup cycle
		acc      = psel && penable && q.pready;
		d.pready = psel && !penable;
		if (psel && !penable) begin
			d.pslverr = !addr_hit(paddr);
			d.prdata  = 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					ADDR_CTRL:   d.prdata = {30'h0, q.ctrl};
					ADDR_STATUS: d.prdata = {18'h0, q.ok, q.toggling, q.pg_started,
					                         q.rts, q.osc, q.bus_pull, s.stop_bus_hi,
					                         s.vdd_ok, s.vcc_ok, s.en_ok, q.st};
					ADDR_CONFIG: d.prdata = {20'h0, q.relay, q.ph_cfg};
					default:     d.prdata = 32'h0000_0000;
				endcase
			end
		end else if (!psel) begin
			d.pslverr = 1'b0;
		end
		if (acc && pwrite && paddr == ADDR_CTRL) begin
			d.ctrl = pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q          <= '0;
			q.ctrl     <= CTRL_RST;
			q.low_pwr  <= 1'b1;
			q.bus_pull <= 1'b1;
			q.ok_oe    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign pready          = q.pready;
	assign prdata          = q.prdata;
	assign pslverr         = q.pslverr;
	assign vcc_reg_en      = q.vcc_en;
	assign vdd_reg_en      = q.vdd_en;
	assign low_power       = q.low_pwr;
	assign ready_to_start  = q.rts;
	assign phase_cfg       = q.ph_cfg;
	assign relay_delay_deg = q.relay;
	assign osc_en          = q.osc;
	assign stop_bus_oe     = q.bus_pull;
	assign high_side_gate  = q.hg;
	assign low_side_gate   = q.lg;
	assign diode_emulation = q.diode;
	assign ea_low_bias_sel = q.low_bias;
	assign ref_sel_track   = q.ref_trk;
	assign ea_offset_mv    = q.offs;
	assign duty_dec        = q.dec;
	assign duty_inc        = q.inc;
	// open drain: pull low while not ok
	assign output_ok_flag  = q.ok;
	assign output_ok_oe    = q.ok_oe;
endmodule : bsts_seq

// file: bench/bsts_seq_sva.sv
`timescale 1ns/1ps
module bsts_seq_sva #(
	parameter int unsigned SYNC_CYC = 20,
	parameter int unsigned PG_CYC   = 20
) (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// watched outputs
	input wire logic       low_power,
	input wire logic       vcc_reg_en,
	input wire logic       vdd_reg_en,
	input wire logic       ready_to_start,
	input wire logic       osc_en,
	input wire logic       stop_bus_oe,
	input wire logic [1:0] high_side_gate,
	input wire logic [1:0] low_side_gate,
	input wire logic       ea_low_bias_sel,
	input wire logic [5:0] ea_offset_mv,
	input wire logic       output_ok_flag
);
	// slack of two for the timer start edge
	localparam int unsigned PG_MIN = PG_CYC - 2;
	logic       seen_q;
	logic [7:0] lg_q;
	logic [7:0] age_q;
	// saturating, so a long run never wraps into a fail
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 1'b0;
			lg_q   <= 8'h00;
			age_q  <= 8'h00;
		end else begin
			seen_q <= !stop_bus_oe && (seen_q || (|high_side_gate));
			lg_q   <= (low_side_gate == 2'h3) ? lg_q + {7'h00, lg_q != 8'hff} : 8'h00;
			age_q  <= seen_q ? age_q + {7'h00, age_q != 8'hff} : 8'h00;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cfg;
		ready_to_start && !osc_en;
	endsequence
	sequence s_sync;
		osc_en && stop_bus_oe;
	endsequence
	a_off_regs_down: assert property (low_power |-> !vcc_reg_en && !vdd_reg_en)
		else $error("regulator on in low power");
	a_osc_after_cfg: assert property ($rose(ready_to_start) |-> s_cfg ##1 s_sync)
		else $error("oscillator not right after config");
	a_sync_wait: assert property ($fell(stop_bus_oe) |-> $past(osc_en, SYNC_CYC))
		else $error("stop bus released early");
	a_gates_parked: assert property (stop_bus_oe |-> high_side_gate == 2'h0 && low_side_gate == 2'h0)
		else $error("gate driven while bus held");
	a_boot_first: assert property ((|high_side_gate) && !seen_q |-> lg_q >= 8'h0c)
		else $error("boot pulse too short");
	a_pg_wait: assert property ($rose(output_ok_flag) |-> age_q >= PG_MIN)
		else $error("output ok too early");
	a_ok_needs_track: assert property (output_ok_flag |-> !ea_low_bias_sel && !stop_bus_oe)
		else $error("output ok without conditions");
	a_offset_cap: assert property (ea_offset_mv <= 6'h28)
		else $error("offset above ceiling");
endmodule : bsts_seq_sva

bind bsts_seq bsts_seq_sva #(.SYNC_CYC(SYNC_CYC), .PG_CYC(PG_CYC)) bsts_seq_sva_inst (
	.pclk(pclk), .presetn(presetn), .low_power(low_power), .vcc_reg_en(vcc_reg_en),
	.vdd_reg_en(vdd_reg_en), .ready_to_start(ready_to_start), .osc_en(osc_en),
	.stop_bus_oe(stop_bus_oe), .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
	.ea_low_bias_sel(ea_low_bias_sel), .ea_offset_mv(ea_offset_mv),
	.output_ok_flag(output_ok_flag)
);

// file: bench/bsts_far_model.sv
`timescale 1ns/1ps
module bsts_far_model #(
	parameter int unsigned HOLD_CYC = 10,
	parameter int unsigned RISE_CYC = 5
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// bus and loop
	input  wire logic stop_bus_oe,
	input  wire logic loop_go,
	output logic      stop_bus_hi,
	output logic      comp_above_low
);
	logic [7:0] hold_q;
	logic [7:0] rise_q;
	// a slower controller keeps the bus low after this one lets go
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 8'h00;
			rise_q <= 8'h00;
		end else begin
			hold_q <= stop_bus_oe ? 8'h00 : hold_q + {7'h00, hold_q < 8'(HOLD_CYC)};
			rise_q <= (stop_bus_hi && loop_go) ? rise_q + {7'h00, rise_q < 8'(RISE_CYC)} : 8'h00;
		end
	end
	// wired low by anyone, pull-up otherwise
	assign stop_bus_hi    = !stop_bus_oe && (hold_q >= 8'(HOLD_CYC));
	assign comp_above_low = rise_q >= 8'(RISE_CYC);
endmodule : bsts_far_model

// file: bench/test_buck_startup_track_sequencer.sv
`timescale 1ns/1ps
module test_buck_startup_track_sequencer import bsts_pkg::*; ;
	typedef struct packed {
		logic [2:0] code;
		logic [8:0] deg;
		logic [7:0] t;
		logic [5:0] off;
	} bsts_row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  pwm_req, hsg, lsg, dec, inc;
	logic [2:0]  pcfg;
	logic [8:0]  relay;
	logic [5:0]  offs;
	logic        vcc_en, vdd_en, lowp, rts, osc, oe, de, lbs, rsel, ok, ok_oe, bus_hi, loop_lo, go;
	logic [7:0]  watch;
	bsts_pins_t  pins_tb, pins;
	int          err_total, checks_done;
	bsts_row_t   rows [7] = '{'{3'h0, 9'h05a, 8'h00, 6'h28}, '{3'h1, 9'h078, 8'h07, 6'h24},
		'{3'h2, 9'h048, 8'h23, 6'h14}, '{3'h3, 9'h03c, 8'h32, 6'h0b}, '{3'h4, 9'h02d, 8'h45, 6'h00},
		'{3'h5, 9'h024, 8'h46, 6'h00}, '{3'h6, 9'h01e, 8'hff, 6'h00}};
	bsts_seq #(.SYNC_CYC(20), .PG_CYC(20)) bsts_seq_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pins_async(pins), .pwm_req(pwm_req), .vcc_reg_en(vcc_en), .vdd_reg_en(vdd_en),
		.low_power(lowp), .ready_to_start(rts), .phase_cfg(pcfg), .relay_delay_deg(relay),
		.osc_en(osc), .stop_bus_oe(oe), .high_side_gate(hsg), .low_side_gate(lsg),
		.diode_emulation(de), .ea_low_bias_sel(lbs), .ref_sel_track(rsel), .ea_offset_mv(offs),
		.duty_dec(dec), .duty_inc(inc), .output_ok_flag(ok), .output_ok_oe(ok_oe)
	);
	bsts_far_model bsts_far_model_inst (
		.pclk(pclk), .presetn(presetn), .stop_bus_oe(oe), .loop_go(go),
		.stop_bus_hi(bus_hi), .comp_above_low(loop_lo)
	);
	assign watch = {ok, lsg[0], hsg[0], oe, vdd_en, vcc_en, rts, lowp};
	always_comb begin
		pins = pins_tb;
		pins.stop_bus_hi = bus_hi;
		pins.comp_above_low = loop_lo;
	end
	task automatic test_done();
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// bounded wait, sampled at the falling edge where outputs are settled
	task automatic wait_on(input int k, input logic v, input int n);
		int i;
		i = 0;
		while (watch[k] !== v && i < n) begin
			@(negedge pclk);
			i++;
		end
		chk("watch bit", 32'(v), 32'(watch[k]));
		if (watch[k] !== v) begin
			test_done();
		end
	endtask : wait_on
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, 32'(pready));
		if (pready !== 1'b1) begin
			test_done();
		end
	endtask : apb
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pwm_req, go} = '0;
		err_total = 0;
		checks_done = 0;
		pins_tb = '0;
		pins_tb.vcc_ok = 1'b1;
		pins_tb.vdd_ok = 1'b1;
		pins_tb.track_below_vref = 1'b1;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		chk("low_power", 32'h1, 32'(lowp));
		chk("stop_bus_oe", 32'h1, 32'(oe));
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", {30'h0, CTRL_RST}, rd);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("pslverr", 32'h1, 32'(serr));
		apb(1'b1, ADDR_CTRL, 32'h3);
		foreach (rows[r]) begin
			@(posedge pclk);
			pins_tb.en_ok <= 1'b0;
			wait_on(0, 1'b1, 8);
			@(posedge pclk);
			pins_tb.phase_count_select <= rows[r].code;
			pins_tb.track_mv <= rows[r].t;
			pins_tb.en_ok <= 1'b1;
			wait_on(1, 1'b1, 5);
			chk("phase_cfg", 32'(rows[r].code), 32'(pcfg));
			chk("relay", 32'(rows[r].deg), 32'(relay));
			chk("offset", 32'(rows[r].off), 32'(offs));
			chk("low_bias", 32'h1, 32'(lbs));
			chk("ref_sel", 32'h1, 32'(rsel));
		end
		@(posedge pclk);
		pins_tb.en_ok <= 1'b0;
		pins_tb.vcc_ok <= 1'b0;
		pins_tb.vdd_ok <= 1'b0;
		wait_on(0, 1'b1, 8);
		@(posedge pclk);
		pins_tb.en_ok <= 1'b1;
		wait_on(2, 1'b1, 8);
		chk("vdd_reg_en", 32'h0, 32'(vdd_en));
		@(posedge pclk);
		pins_tb.vcc_ok <= 1'b1;
		wait_on(3, 1'b1, 8);
		chk("ready", 32'h0, 32'(rts));
		@(posedge pclk);
		pins_tb.vdd_ok <= 1'b1;
		wait_on(1, 1'b1, 8);
		wait_on(4, 1'b0, 40);
		chk("stop_bus_hi", 32'h0, 32'(bus_hi));
		wait_on(6, 1'b1, 20);
		@(posedge pclk);
		go <= 1'b1;
		pwm_req <= 2'h1;
		pins_tb.comp_above_ramp <= 1'b1;
		pins_tb.fb_above_uv <= 1'b1;
		pins_tb.track_below_vref <= 1'b0;
		pins_tb.i_above_avg <= 2'h1;
		pins_tb.i_below_avg <= 2'h2;
		wait_on(5, 1'b1, 40);
		chk("ok", 32'h0, 32'(ok));
		chk("duty_dec", 32'h1, 32'(dec));
		chk("duty_inc", 32'h2, 32'(inc));
		chk("low_bias", 32'h0, 32'(lbs));
		chk("ref_sel", 32'h0, 32'(rsel));
		chk("lsg", 32'h2, 32'(lsg));
		chk("diode", 32'h0, 32'(de));
		wait_on(7, 1'b1, 40);
		chk("ok_oe", 32'h0, 32'(ok_oe));
		apb(1'b0, ADDR_CONFIG, 32'h0);
		chk("config", {20'h0, 9'h01e, 3'h6}, rd);
		// slave role: ok needs the lock pin to toggle
		apb(1'b1, ADDR_CTRL, 32'h1);
		wait_on(7, 1'b0, 6);
		@(posedge pclk);
		pins_tb.clk_lock <= 1'b1;
		wait_on(7, 1'b1, 8);
		apb(1'b1, ADDR_CTRL, 32'h3);
		@(posedge pclk);
		pins_tb.fault_present <= 1'b1;
		wait_on(7, 1'b0, 6);
		@(posedge pclk);
		pins_tb.fault_restart <= 1'b1;
		repeat (4) @(negedge pclk);
		chk("diode", 32'h1, 32'(de));
		chk("lsg", 32'h0, 32'(lsg));
		@(posedge pclk);
		pins_tb.vdd_ok <= 1'b0;
		wait_on(4, 1'b1, 6);
		chk("hsg", 32'h0, 32'(hsg));
		chk("low_power", 32'h0, 32'(lowp));
		@(posedge pclk);
		pins_tb.vdd_ok <= 1'b1;
		wait_on(1, 1'b1, 10);
		test_done();
	end
endmodule : test_buck_startup_track_sequencer
